// >>> sim/rcs_partner.sv
// paper-tape reader model on the serial side of the block
`timescale 1ns/100ps
module rcs_partner (
  input  wire logic CLOCK,
  input  wire logic TAPE_ADVANCE,
  output      logic SERIAL_IN,
  output      logic CHAR_AVAILABLE
);
  // ==========================================================
  // one frame per advance; line idles at mark so no false start
  initial begin
    SERIAL_IN = 1'b1;
    CHAR_AVAILABLE = 1'b0;
    forever begin
      @(posedge CLOCK);
      #2;
      if (TAPE_ADVANCE === 1'b1) begin
        repeat (20) @(posedge CLOCK);
        #2 SERIAL_IN = 1'b0;
        repeat (10) @(posedge CLOCK);
        #2 SERIAL_IN = 1'b1;
        repeat (6) @(posedge CLOCK);
        #2 CHAR_AVAILABLE = 1'b1;
        @(posedge CLOCK);
        #2 CHAR_AVAILABLE = 1'b0;
      end
    end
  end
endmodule : rcs_partner

// >>> sim/rcs_receiver_control_asserts.sv
// port checker for the receiver control/status block
`timescale 1ns/100ps
module rcs_rc_asserts #(parameter bit ROUTE_TO_FORCE_BUSY = 1'b0) (
  input wire logic        CLOCK,
  input wire logic        NRST,
  input wire logic        BUS_INITIALIZE,
  input wire logic        CSR_WRITE,
  input wire logic [15:0] WDATA,
  input wire logic        BUFFER_SELECT,
  input wire logic        CLEAR_READY,
  input wire logic        RECEIVE_IRQ_REQUEST,
  input wire logic        SERIAL_IN,
  input wire logic        REQUEST_TO_SEND,
  input wire logic        FORCE_BUSY_LINE,
  input wire logic        TERMINAL_READY,
  input wire logic        REVERSE_CHANNEL_TX,
  input wire logic        TAPE_ADVANCE
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!NRST);
  // ==========================================================
  // line steps; idle long enough that no start can fire
  sequence s_idle_write;
    SERIAL_IN [*8] ##0 (CSR_WRITE && !BUS_INITIALIZE);
  endsequence
  sequence s_start_bit;
    SERIAL_IN ##1 (!SERIAL_IN && !CSR_WRITE) [*8];
  endsequence
  a_tape_write: assert property (s_idle_write |=> TAPE_ADVANCE == $past(WDATA[0]))
    else $error("tape advance not loaded");
  a_start_stops: assert property (s_start_bit |-> !TAPE_ADVANCE)
    else $error("start bit left tape advance on");
  a_write_bits: assert property (CSR_WRITE && !BUS_INITIALIZE |=>
    REVERSE_CHANNEL_TX == $past(WDATA[3]) && TERMINAL_READY == $past(WDATA[1]))
    else $error("control bits not loaded");
  a_rts_write: assert property (CSR_WRITE && !BUS_INITIALIZE |=>
    REQUEST_TO_SEND == ($past(WDATA[2]) && !ROUTE_TO_FORCE_BUSY)) else $error("rts wrong");
  a_rts_route: assert property (!(REQUEST_TO_SEND && FORCE_BUSY_LINE) &&
    (ROUTE_TO_FORCE_BUSY || !FORCE_BUSY_LINE)) else $error("rts routed wrongly");
  a_dtr_hold: assert property (BUS_INITIALIZE && !CSR_WRITE |=> $stable(TERMINAL_READY))
    else $error("terminal ready moved on init");
  a_init_clears: assert property (BUS_INITIALIZE && !CSR_WRITE |=>
    !(REVERSE_CHANNEL_TX || REQUEST_TO_SEND || TAPE_ADVANCE || RECEIVE_IRQ_REQUEST))
    else $error("init left a bit set");
  a_buf_clear: assert property (BUFFER_SELECT |=> CLEAR_READY)
    else $error("no clear ready on buffer access");
  a_tape_clear: assert property (TAPE_ADVANCE |=> CLEAR_READY)
    else $error("no clear ready while reader on");
endmodule : rcs_rc_asserts

bind rcs_receiver_control rcs_rc_asserts #(.ROUTE_TO_FORCE_BUSY(ROUTE_TO_FORCE_BUSY))
  rcs_rc_asserts_i (.CLOCK(CLOCK), .NRST(NRST), .BUS_INITIALIZE(BUS_INITIALIZE),
  .CSR_WRITE(CSR_WRITE), .WDATA(WDATA), .BUFFER_SELECT(BUFFER_SELECT),
  .CLEAR_READY(CLEAR_READY), .RECEIVE_IRQ_REQUEST(RECEIVE_IRQ_REQUEST),
  .SERIAL_IN(SERIAL_IN), .REQUEST_TO_SEND(REQUEST_TO_SEND),
  .FORCE_BUSY_LINE(FORCE_BUSY_LINE), .TERMINAL_READY(TERMINAL_READY),
  .REVERSE_CHANNEL_TX(REVERSE_CHANNEL_TX), .TAPE_ADVANCE(TAPE_ADVANCE));

// >>> sim/test_rcs_receiver_control.sv
// self-checking bench for the receiver control/status block
`timescale 1ns/100ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
  $display("ERROR %s expected %h seen %h", n, e, g); end end
module test_rcs_receiver_control;
  logic CLOCK = 0, NRST = 0, BUS_INITIALIZE = 0, CSR_READ = 0, CSR_WRITE = 0;
  logic BUFFER_SELECT = 0, RING = 0, CARRIER = 0, CLEAR_TO_SEND = 0, REVERSE_CHANNEL_RX = 0;
  logic [15:0] WDATA = 16'h0000, RDATA;
  logic SERIAL_IN, CHAR_AVAILABLE, CLEAR_READY, RECEIVE_IRQ_REQUEST, REQUEST_TO_SEND;
  logic FORCE_BUSY_LINE, TERMINAL_READY, REVERSE_CHANNEL_TX, TAPE_ADVANCE;
  int n_fail = 0, tests_run = 0, i;
  always #12.5 CLOCK = ~CLOCK;
  rcs_receiver_control rcs_receiver_control_i (.CLOCK(CLOCK), .NRST(NRST),
    .BUS_INITIALIZE(BUS_INITIALIZE), .CSR_READ(CSR_READ), .CSR_WRITE(CSR_WRITE),
    .WDATA(WDATA), .RDATA(RDATA), .BUFFER_SELECT(BUFFER_SELECT),
    .CHAR_AVAILABLE(CHAR_AVAILABLE), .CLEAR_READY(CLEAR_READY),
    .RECEIVE_IRQ_REQUEST(RECEIVE_IRQ_REQUEST), .SERIAL_IN(SERIAL_IN), .RING(RING),
    .CARRIER(CARRIER), .CLEAR_TO_SEND(CLEAR_TO_SEND), .REVERSE_CHANNEL_RX(REVERSE_CHANNEL_RX),
    .REQUEST_TO_SEND(REQUEST_TO_SEND), .FORCE_BUSY_LINE(FORCE_BUSY_LINE),
    .TERMINAL_READY(TERMINAL_READY), .REVERSE_CHANNEL_TX(REVERSE_CHANNEL_TX),
    .TAPE_ADVANCE(TAPE_ADVANCE));
  rcs_partner rcs_partner_i (.CLOCK(CLOCK), .TAPE_ADVANCE(TAPE_ADVANCE),
    .SERIAL_IN(SERIAL_IN), .CHAR_AVAILABLE(CHAR_AVAILABLE));
  // ==========================================================
  // bus cycles and helpers
  task tick; @(posedge CLOCK); #2; endtask : tick
  task wr(input logic [15:0] v); CSR_WRITE = 1; WDATA = v; tick; CSR_WRITE = 0; endtask : wr
  task rd(input logic [15:0] e, input string n);
    CSR_READ = 1; tick; CSR_READ = 0; tick; `CHK(n, e, RDATA)
  endtask : rd
  task guard; if (i >= 200) begin n_fail++; stop_test; end endtask : guard
  task stop_test;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test
  // ==========================================================
  // scenarios
  task t_basic;
    repeat (8) tick;
    rd(16'h0000, "reset read");
    wr(16'hffff);
    rd(16'h006e, "write all");
    `CHK("tape", 1'b1, TAPE_ADVANCE)
    `CHK("busy", 1'b0, FORCE_BUSY_LINE)
  endtask : t_basic
  task t_reader;
    for (i = 0; i < 200 && TAPE_ADVANCE !== 1'b0; i++) tick;
    guard;
    rd(16'h086e, "active");
    for (i = 0; i < 200 && RECEIVE_IRQ_REQUEST !== 1'b1; i++) tick;
    guard;
    rd(16'h00ee, "done");
    BUFFER_SELECT = 1; tick; BUFFER_SELECT = 0;
    `CHK("clear ready", 1'b1, CLEAR_READY)
    tick; `CHK("irq off", 1'b0, RECEIVE_IRQ_REQUEST)
  endtask : t_reader
  task t_modem;
    CARRIER = 1; repeat (5) tick;
    `CHK("modem irq", 1'b1, RECEIVE_IRQ_REQUEST)
    rd(16'h906e, "carrier");
    RING = 1; repeat (5) tick;
    rd(16'hd06e, "ring rise");
    RING = 0; repeat (5) tick;
    rd(16'h106e, "ring fall");
    `CHK("irq after read", 1'b0, RECEIVE_IRQ_REQUEST)
  endtask : t_modem
  task t_init;
    BUS_INITIALIZE = 1; tick; BUS_INITIALIZE = 0;
    rd(16'h1002, "init");
    wr(16'h0000);
    rd(16'h1000, "zeros");
    `CHK("dtr", 1'b0, TERMINAL_READY)
  endtask : t_init
  initial begin
    repeat (2) @(posedge CLOCK);
    #2 NRST = 1;
    t_basic; t_reader; t_modem; t_init;
    stop_test;
  end
endmodule : test_rcs_receiver_control

// >>> src/rcs_pkg.sv
// receiver control/status bit layout and state type
package rcs_pkg;

  // ==========================================================
  // bit positions of receiver_control_status
  localparam int unsigned RCS_MODEM_CHANGE_BIT  = 15;
  localparam int unsigned RCS_RING_BIT          = 14;
  localparam int unsigned RCS_CTS_BIT           = 13;
  localparam int unsigned RCS_CARRIER_BIT       = 12;
  localparam int unsigned RCS_RX_ACTIVE_BIT     = 11;
  localparam int unsigned RCS_REV_RX_BIT        = 10;
  localparam int unsigned RCS_CHAR_RECEIVED_BIT = 7;
  localparam int unsigned RCS_RX_IRQ_EN_BIT     = 6;
  localparam int unsigned RCS_MODEM_IRQ_EN_BIT  = 5;
  localparam int unsigned RCS_REV_TX_BIT        = 3;
  localparam int unsigned RCS_RTS_BIT           = 2;
  localparam int unsigned RCS_DTR_BIT           = 1;
  localparam int unsigned RCS_TAPE_ADV_BIT      = 0;

  // ==========================================================
  // widths, start pattern and reset values
  localparam int unsigned RCS_DATA_W       = 16;
  localparam int unsigned RCS_START_DET_W  = 4;
  localparam int unsigned RCS_SYNC_W       = 5;
  localparam logic [3:0]  RCS_START_PATTERN = 4'h8;
  localparam logic [15:0] RCS_RDATA_RESET   = 16'h0000;
  localparam logic [3:0]  RCS_SHIFT_RESET   = 4'hf;
  localparam logic [4:0]  RCS_SYNC_RESET    = 5'h00;

  // ==========================================================
  // whole module state
  typedef struct packed {
    logic [4:0]  sync1;
    logic [4:0]  sync2;
    logic [4:0]  prev;
    logic [3:0]  start_shift;
    logic        char_received_flag;
    logic        receiver_active_flag;
    logic        modem_change_flag;
    logic        receive_irq_enable;
    logic        modem_irq_enable;
    logic        reverse_channel_tx;
    logic        rts;
    logic        dtr;
    logic        tape_advance_enable;
    logic        irq;
    logic        clear_ready;
    logic        rts_line;
    logic        force_busy_line;
    logic [15:0] rdata;
  } rcs_state_t;

endpackage : rcs_pkg

// >>> src/rcs_receiver_control.sv
// receiver control/status register bits with modem and reader control
//
// Functional notes
// [R1] Receive irq request when char-received flag and enable bit 06 both set.
// [R2] Register read shows char-received flag on data line 7.
// [R3] Char-received flag clears on bus initialize or buffer access via clear-ready.
// [R4] Tape-advance enable set holds char-received flag cleared through clear-ready.
// [R5] Receive irq enable loads from data bit 6 on write, reads on line 6.
// [R6] Bus initialize clears receive irq enable.
// [R7] Modem irq enable loads from bit 5; with modem-change flag raises irq.
// [R8] Modem irq enable reads on line 5, cleared by bus initialize.
// [R9] Reverse-channel transmit loads from bit 3, drives output, reads on line 3.
// [R10] Bus initialize clears reverse-channel transmit.
// [R11] Request-to-send loads from bit 2, drives output, reads line 2, init clears.
// [R12] Build option routes request-to-send to rts line or force-busy, never both.
// [R13] Terminal-ready takes data bit 1 on every write, reads on line 1.
// [R14] Terminal-ready ignores bus initialize; only a written zero or power-on reset clears it.
// [R15] Tape-advance enable loads from bit 0 and drives reader-advance output.
// [R16] Tape-advance enable is write-only and reads as zero.
// [R17] Serial input feeds 4-bit start detector; mid start bit clears tape-advance.
// [R18] Start detection sets receiver-active flag.
// [R19] Bus initialize clears tape-advance enable.
// [R20] Character available sets char-received flag and clears receiver-active.
// [R21] Modem-change sets on ring rise or any edge of carrier, cts, reverse rx.
// [R22] Modem-change clears on register read and on bus initialize.
// [R23] Written zero clears writable bits; write-only and unused bits read zero.
// [R24] Software enables irq and checks receiver idle before starting the reader.
`timescale 1ns/100ps

module rcs_receiver_control
  import rcs_pkg::*;
#(
  parameter bit ROUTE_TO_FORCE_BUSY = 1'b0
) (
  input  wire logic                  CLOCK,
  input  wire logic                  NRST,
  input  wire logic                  BUS_INITIALIZE,
  input  wire logic                  CSR_READ,
  input  wire logic                  CSR_WRITE,
  input  wire logic [RCS_DATA_W-1:0] WDATA,
  output      logic [RCS_DATA_W-1:0] RDATA,
  input  wire logic                  BUFFER_SELECT,
  input  wire logic                  CHAR_AVAILABLE,
  output      logic                  CLEAR_READY,
  output      logic                  RECEIVE_IRQ_REQUEST,
  input  wire logic                  SERIAL_IN,
  input  wire logic                  RING,
  input  wire logic                  CARRIER,
  input  wire logic                  CLEAR_TO_SEND,
  input  wire logic                  REVERSE_CHANNEL_RX,
  output      logic                  REQUEST_TO_SEND,
  output      logic                  FORCE_BUSY_LINE,
  output      logic                  TERMINAL_READY,
  output      logic                  REVERSE_CHANNEL_TX,
  output      logic                  TAPE_ADVANCE
);

  // ==========================================================
  // state
  rcs_state_t st;
  rcs_state_t next_st;

  // pin order in the synchroniser: serial, ring, cts, carrier, reverse rx
  logic [RCS_SYNC_W-1:0] pins;
  assign pins = {SERIAL_IN, RING, CLEAR_TO_SEND, CARRIER, REVERSE_CHANNEL_RX};

  // ==========================================================
  // next state
  always_comb begin
    logic       start_event;
    logic       modem_event;
    logic       hold_clear;
    logic [RCS_START_DET_W-1:0] shift_next;
    start_event = 1'b0;
    modem_event = 1'b0;
    hold_clear  = 1'b0;
    shift_next  = RCS_SHIFT_RESET;
    next_st = st;

    // first stage is read only by the second stage
    next_st.sync1 = pins;
    next_st.sync2 = st.sync1;
    next_st.prev  = st.sync2;

    // newest sample enters bit 0; mark then three spaces marks mid start bit
    shift_next = {st.start_shift[2:0], st.sync2[4]}; // R17
    next_st.start_shift = shift_next;
    start_event = (shift_next == RCS_START_PATTERN); // R17

    // ring counts only rising; the rest count both edges
    modem_event = (st.sync2[3] & ~st.prev[3])
                | (st.sync2[2] ^ st.prev[2])
                | (st.sync2[1] ^ st.prev[1])
                | (st.sync2[0] ^ st.prev[0]); // R21

    // register write: every writable bit takes the written value
    if (CSR_WRITE) begin
      next_st.receive_irq_enable  = WDATA[RCS_RX_IRQ_EN_BIT]; // R5 R23
      next_st.modem_irq_enable    = WDATA[RCS_MODEM_IRQ_EN_BIT]; // R7
      next_st.reverse_channel_tx  = WDATA[RCS_REV_TX_BIT]; // R9
      next_st.rts                 = WDATA[RCS_RTS_BIT]; // R11
      next_st.dtr                 = WDATA[RCS_DTR_BIT]; // R13 R14
      next_st.tape_advance_enable = WDATA[RCS_TAPE_ADV_BIT]; // R15
    end

    // start detector overrides a write in the same cycle
    if (start_event) begin
      next_st.tape_advance_enable = 1'b0; // R17
    end

    // receiver active: a finished character beats a new start edge
    if (start_event) begin
      next_st.receiver_active_flag = 1'b1; // R18
    end
    if (CHAR_AVAILABLE) begin
      next_st.receiver_active_flag = 1'b0; // R20
    end

    // clear path shared by buffer access and an advancing reader
    hold_clear = BUFFER_SELECT | st.tape_advance_enable; // R3 R4
    if (hold_clear) begin
      next_st.char_received_flag = 1'b0; // R3 R4
    end
    // arrival wins over a buffer access, not over an advancing reader
    if (CHAR_AVAILABLE & ~st.tape_advance_enable) begin
      next_st.char_received_flag = 1'b1; // R20
    end

    // read-once flag; a change in the read cycle survives
    if (CSR_READ) begin
      next_st.modem_change_flag = 1'b0; // R22
    end
    if (modem_event) begin
      next_st.modem_change_flag = 1'b1; // R21
    end

    // terminal-ready is left out so a reset instruction keeps the line up
    if (BUS_INITIALIZE) begin
      next_st.char_received_flag   = 1'b0; // R3
      next_st.receiver_active_flag = 1'b0;
      next_st.modem_change_flag    = 1'b0; // R22
      next_st.receive_irq_enable   = 1'b0; // R6
      next_st.modem_irq_enable     = 1'b0; // R8
      next_st.reverse_channel_tx   = 1'b0; // R10
      next_st.rts                  = 1'b0; // R11
      next_st.tape_advance_enable  = 1'b0; // R19
    end

    // ==========================================================
    // registered outputs: irq and rts lines follow the next bit values, clear-ready the current inputs and tape-advance bit
    next_st.clear_ready = BUS_INITIALIZE | hold_clear; // R3 R4
    next_st.irq = (next_st.char_received_flag & next_st.receive_irq_enable)
                | (next_st.modem_change_flag & next_st.modem_irq_enable); // R1 R7
    next_st.rts_line        = ROUTE_TO_FORCE_BUSY ? 1'b0 : next_st.rts; // R12
    next_st.force_busy_line = ROUTE_TO_FORCE_BUSY ? next_st.rts : 1'b0; // R12

    // read image from current bits; tape-advance stays zero
    if (CSR_READ) begin
      next_st.rdata = RCS_RDATA_RESET; // R16 R23
      next_st.rdata[RCS_MODEM_CHANGE_BIT]  = st.modem_change_flag;
      next_st.rdata[RCS_RING_BIT]          = st.sync2[3];
      next_st.rdata[RCS_CTS_BIT]           = st.sync2[2];
      next_st.rdata[RCS_CARRIER_BIT]       = st.sync2[1];
      next_st.rdata[RCS_RX_ACTIVE_BIT]     = st.receiver_active_flag;
      next_st.rdata[RCS_REV_RX_BIT]        = st.sync2[0];
      next_st.rdata[RCS_CHAR_RECEIVED_BIT] = st.char_received_flag; // R2
      next_st.rdata[RCS_RX_IRQ_EN_BIT]     = st.receive_irq_enable; // R5
      next_st.rdata[RCS_MODEM_IRQ_EN_BIT]  = st.modem_irq_enable; // R8
      next_st.rdata[RCS_REV_TX_BIT]        = st.reverse_channel_tx; // R9
      next_st.rdata[RCS_RTS_BIT]           = st.rts; // R11
      next_st.rdata[RCS_DTR_BIT]           = st.dtr; // R13
    end
  end

  // ==========================================================
  // state register; apart from a written zero, power-on reset is the only thing that drops terminal-ready
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      st             <= '0;
      st.sync1       <= RCS_SYNC_RESET;
      st.sync2       <= RCS_SYNC_RESET;
      st.prev        <= RCS_SYNC_RESET;
      st.start_shift <= RCS_SHIFT_RESET;
      st.rdata       <= RCS_RDATA_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // outputs
  assign RDATA               = st.rdata;
  assign CLEAR_READY         = st.clear_ready;
  assign RECEIVE_IRQ_REQUEST = st.irq;
  assign REQUEST_TO_SEND     = st.rts_line;
  assign FORCE_BUSY_LINE     = st.force_busy_line;
  assign TERMINAL_READY      = st.dtr;
  assign REVERSE_CHANNEL_TX  = st.reverse_channel_tx;
  assign TAPE_ADVANCE        = st.tape_advance_enable; // R15

endmodule : rcs_receiver_control
